// file: adc_ctl_pkg.sv
// package for the converter control block: register map, field layout,
// timing counts and the shared state and carrier types.
// assumes a 200 MHz system clock and a word-addressed register bus.
package adc_ctl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_PERIOD_NS = 5;                       // system clock period
   localparam int TAD_DIV0_CYC  = 2;                       // code 00 divide
   localparam int TAD_DIV1_CYC  = 8;                       // code 01 divide
   localparam int TAD_DIV2_CYC  = 32;                      // code 10 divide
   localparam int TAD_RC_NS     = 4000;                    // internal rc period, typical
   localparam int TAD_RC_CYC    = TAD_RC_NS / CLK_PERIOD_NS;
   localparam int CONV_TADS     = 12;                      // periods per conversion
   localparam int BIT_TICKS     = 10;                      // bit decisions
   localparam int HOLD_TADS     = 2;                       // holdoff after end or abort
   localparam int TAD_CNT_W     = 10;                      // divider counter width

   ////////////////////////////////////////////////////////////////////////
   // register word indices
   localparam logic [2:0] REG_CTRL   = 3'h0;               // converter_control_reg
   localparam logic [2:0] REG_FMT    = 3'h1;               // result_format_port_config
   localparam logic [2:0] REG_RES_HI = 3'h2;               // result_high_byte
   localparam logic [2:0] REG_RES_LO = 3'h3;               // result_low_byte
   localparam logic [2:0] REG_STATUS = 3'h4;               // done flag
   localparam logic [2:0] REG_PORT   = 3'h5;               // port pin readback

   ////////////////////////////////////////////////////////////////////////
   // field positions and masks
   localparam int CTRL_PWR  = 0;                           // converter_power_on
   localparam int CTRL_GO   = 2;                           // conversion go flag
   localparam int CTRL_CH   = 3;                           // channel_select_field lsb
   localparam int CTRL_CS   = 6;                           // conversion_clock_select lsb
   localparam int FMT_RIGHT = 7;                           // result_format_select
   localparam logic [7:0] CTRL_MASK = 8'hFD;               // bit 1 unimplemented
   localparam logic [7:0] FMT_MASK  = 8'h8F;               // bits 6..4 unimplemented
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] FMT_RST   = 8'h00;               // all pins analog
   localparam logic [7:0] RES_RST   = 8'h00;
   localparam logic [9:0] SAR_MSB   = 10'h200;             // first trial bit

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {PH_OFF, PH_ACQ, PH_FIRST, PH_CONV, PH_HOLD} phase_type;

   // analog front-end controls
   typedef struct packed {
      logic       powered;                                 // converter biased
      logic [2:0] channel;                                 // selected input
      logic       connect;                                 // sample switch closed
      logic       vref_pos_ext;                            // pin_a3 as positive ref
      logic       vref_neg_ext;                            // pin_a2 as negative ref
      logic [9:0] trial;                                   // dac trial code
   } front_type;

   // clocks per bit_conversion_period for a select code
   function automatic int tad_cycles(input logic [1:0] sel);
      tad_cycles = (sel == 2'h0) ? TAD_DIV0_CYC :
                   (sel == 2'h1) ? TAD_DIV1_CYC :
                   (sel == 2'h2) ? TAD_DIV2_CYC : TAD_RC_CYC;
   endfunction

endpackage

// file: adc_tad_div.sv
// bit_conversion_period tick generator.
// assumes restart is a same-clock pulse from the control fsm.
`timescale 1ns/10ps
module adc_tad_div
   import adc_ctl_pkg::*;
#(
   parameter int RC_CYC = TAD_RC_CYC                       // rc period in clocks
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       restart,
   input  wire logic [1:0] sel,
   // tick out
   output logic            tick
);

   typedef struct packed {
      logic [TAD_CNT_W-1:0] cnt;                           // clocks left in period
      logic                 tick;                          // period end pulse
   } div_state_type;

   div_state_type q, d;
   logic [TAD_CNT_W-1:0] last;                             // reload value

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      last = (sel == 2'h3) ? TAD_CNT_W'(RC_CYC - 1)      // RULE12
                           : TAD_CNT_W'(tad_cycles(sel) - 1); // RULE10
      d = q;
      d.tick = 1'b0;
      if (restart) begin
         // the restart clock is the first clock of the new period
         d.cnt = (last == '0) ? '0 : last - 1'b1;
      end else if (q.cnt == '0) begin
         d.cnt  = last;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   // register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule

// file: adc_port_decode.sv
// port configuration decode: which pins are digital and which references.
// assumes a static four-bit configuration code from a register.
`timescale 1ns/10ps
module adc_port_decode (
   // configuration
   input  wire logic [3:0] port_config_field,
   // decoded
   output logic [4:0]      digital,
   output logic            vref_pos_ext,
   output logic            vref_neg_ext
);

   ////////////////////////////////////////////////////////////////////////
   // pin and reference table
   always_comb begin
      unique case (port_config_field)                                   // RULE4
         4'h4, 4'h5: digital = 5'h14;                      // channels 2 and 4
         4'h6, 4'h7: digital = 5'h1F;                      // all digital
         4'hD:       digital = 5'h10;                      // channel 4
         4'hE:       digital = 5'h1E;                      // only channel 0 analog
         4'hF:       digital = 5'h12;                      // channels 1 and 4
         default:    digital = 5'h00;
      endcase
      vref_neg_ext = (port_config_field == 4'h8) || (port_config_field == 4'hB) || (port_config_field == 4'hC)
                  || (port_config_field == 4'hD) || (port_config_field == 4'hF);     // RULE3
      vref_pos_ext = vref_neg_ext || (port_config_field == 4'h1) || (port_config_field == 4'h3)
                  || (port_config_field == 4'h5) || (port_config_field == 4'hA);     // RULE3
   end

endmodule

// file: adc_conv_ctl.sv
// converter control: register slave, conversion sequencer, result pair.
// assumes an avalon-mm master on clk and a comparator from the analog side.
//
// Notes on behaviour
// RULE1: format 0 left-justifies, low six bits zero
// RULE2: format 1 right-justifies, high six bits zero
// RULE3: configuration code picks the reference pins
// RULE4: configuration code picks which pins are digital
// RULE5: completion loads result, clears go, sets done
// RULE6: software configures, waits acquisition, then sets go
// RULE7: software polls go or awaits interrupt
// RULE8: two periods after completion, capacitor disconnected
// RULE9: conversion lasts at least twelve periods
// RULE10: clock select gives 2, 8, 32 or rc
// RULE11: software keeps period at least 1.6 us
// RULE12: rc period typically 4 us
// RULE13: rc clock above 1 MHz only in sleep
// RULE14: selected pin converted whatever its direction
// RULE15: analog pins read as zero on port
// RULE16: clearing go aborts, result pair untouched
// RULE17: two periods after abort, then acquisition restarts
// RULE18: first segment lasts at most one period
// RULE19: software powers on before setting go
// RULE20: software waits acquisition after channel change
// RULE21: result bytes are plain read/write registers
// RULE22: reset powers off, aborts, all pins analog
// RULE23: channel field picks the sampled input
// RULE24: go ignored while converter powered off
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
module adc_conv_ctl
   import adc_ctl_pkg::*;
#(
   parameter int RC_CYC = TAD_RC_CYC                       // rc period in clocks
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [2:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // analog side
   input  wire logic        comp_hi,
   input  wire logic [4:0]  port_pins,
   output front_type        front,
   // status
   output logic             conversion_done_irq_flag
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      phase_type   phase;                                  // sequencer phase
      logic [7:0]  ctrl;                                   // control register
      logic [7:0]  fmt;                                    // format and port config
      logic [7:0]  res_hi;                                 // result high byte
      logic [7:0]  res_lo;                                 // result low byte
      logic        done;                                   // done flag
      logic [9:0]  sar;                                    // trial register
      logic [3:0]  tick_n;                                 // periods counted
      logic        resp;                                   // bus answer cycle
      logic [31:0] rdata;                                  // read data
      logic [5:0]  sync1;                                  // first sync stage
      logic [5:0]  sync2;                                  // second sync stage
      logic [15:0] conv_cyc;                               // clocks since start
      logic [15:0] hold_cyc;                               // clocks in holdoff
   } state_type;

   state_type q, d;

   logic       tick;                                       // period end
   logic       restart;                                    // divider restart
   logic [4:0] digital;                                    // digital pin mask
   logic       vpos;                                       // external positive ref
   logic       vneg;                                       // external negative ref
   logic       comp_s;                                     // synced comparator
   logic [4:0] pins_s;                                     // synced pins
   logic       sw_we;                                      // write accepted
   logic       powered;                                    // power bit
   logic       converting;                                 // first or bit phase
   logic       complete;                                   // last period ends
   logic [9:0] bitm;                                       // current trial bit
   logic [7:0] port_rd;                                    // port readback
   logic [15:0] tad_len;                                   // clocks per period

   ////////////////////////////////////////////////////////////////////////
   // submodules
   adc_tad_div #(
      .RC_CYC  (RC_CYC)
   ) u_div (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (restart),
      .sel     (q.ctrl[CTRL_CS +: 2]),
      .tick    (tick)
   );

   adc_port_decode u_dec (
      .port_config_field         (q.fmt[3:0]),
      .digital      (digital),
      .vref_pos_ext (vpos),
      .vref_neg_ext (vneg)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers
   assign comp_s     = q.sync2[5];
   assign pins_s     = q.sync2[4:0];
   assign sw_we      = write && q.resp;
   assign powered    = q.ctrl[CTRL_PWR];
   assign converting = (q.phase == PH_FIRST) || (q.phase == PH_CONV);
   assign complete   = (q.phase == PH_CONV) && tick && (q.tick_n == 4'(BIT_TICKS));
   assign bitm       = SAR_MSB >> q.tick_n;
   assign port_rd    = {3'h0, pins_s & digital};           // RULE15
   // period length as the divider reloads it, rc included
   assign tad_len    = (q.ctrl[CTRL_CS +: 2] == 2'h3) ? 16'(RC_CYC)
                     : 16'(tad_cycles(q.ctrl[CTRL_CS +: 2]));

   ////////////////////////////////////////////////////////////////////////
   // next state: bus, registers, sequencer
   always_comb begin
      d         = q;
      restart   = 1'b0;
      d.sync1   = {comp_hi, port_pins};
      d.sync2   = q.sync1;
      d.resp    = (read || write) && !q.resp;
      d.conv_cyc = converting ? q.conv_cyc + 1'b1 : '0;
      d.hold_cyc = (q.phase == PH_HOLD) ? q.hold_cyc + 1'b1 : '0;

      // read mux, sampled in the request cycle
      if (read && !q.resp) begin
         unique case (address)
            REG_CTRL:   d.rdata = {24'h0, q.ctrl};
            REG_FMT:    d.rdata = {24'h0, q.fmt};
            REG_RES_HI: d.rdata = {24'h0, q.res_hi};
            REG_RES_LO: d.rdata = {24'h0, q.res_lo};
            REG_STATUS: d.rdata = {31'h0, q.done};
            REG_PORT:   d.rdata = {24'h0, port_rd};
            default:    d.rdata = 32'h0000_0000;          // unmapped
         endcase
      end

      // software writes
      if (sw_we) begin
         unique case (address)
            REG_CTRL: begin
               d.ctrl = writedata[7:0] & CTRL_MASK;
               if (converting) begin
                  d.ctrl[CTRL_GO] = writedata[CTRL_GO];    // 0 here aborts
               end else begin
                  d.ctrl[CTRL_GO] = writedata[CTRL_GO] && powered
                                 && writedata[CTRL_PWR]
                                 && (q.phase == PH_ACQ);   // RULE24
               end
            end
            REG_FMT:    d.fmt    = writedata[7:0] & FMT_MASK;
            REG_RES_HI: d.res_hi = writedata[7:0];         // RULE21
            REG_RES_LO: d.res_lo = writedata[7:0];         // RULE21
            REG_STATUS: d.done   = q.done && writedata[0]; // write 0 clears
            default: ;
         endcase
      end

      // sequencer
      unique case (q.phase)
         PH_OFF: begin
            if (powered) begin
               d.phase = PH_ACQ;
            end
         end
         PH_ACQ: begin
            if (d.ctrl[CTRL_GO]) begin                     // start taken
               d.phase = PH_FIRST;
               restart = 1'b1;                             // RULE18
            end
         end
         PH_FIRST: begin
            if (tick) begin                                // RULE18
               d.phase  = PH_CONV;
               d.tick_n = '0;
               d.sar    = SAR_MSB;
            end
         end
         PH_CONV: begin
            if (complete) begin                            // RULE9
               d.ctrl[CTRL_GO] = 1'b0;                     // RULE5
               d.done          = 1'b1;                     // RULE5
               if (q.fmt[FMT_RIGHT]) begin
                  d.res_hi = {6'h00, q.sar[9:8]};          // RULE2
                  d.res_lo = q.sar[7:0];                   // RULE2
               end else begin
                  d.res_hi = q.sar[9:2];                   // RULE1
                  d.res_lo = {q.sar[1:0], 6'h00};          // RULE1
               end
               d.phase  = PH_HOLD;                         // RULE8
               d.tick_n = '0;
               restart  = 1'b1;
            end else if (tick) begin
               // keep the trial bit when the input is at or above the trial level
               d.sar    = (comp_s ? q.sar : (q.sar & ~bitm)) | (bitm >> 1); // RULE14
               d.tick_n = q.tick_n + 1'b1;
            end
         end
         PH_HOLD: begin
            if (tick) begin
               d.tick_n = q.tick_n + 1'b1;
               if (q.tick_n == 4'(HOLD_TADS - 1)) begin   // RULE8
                  d.phase = PH_ACQ;                        // RULE17
               end
            end
         end
         default: d.phase = PH_OFF;
      endcase

      // go cleared by software mid-conversion: drop the partial result
      if (converting && !d.ctrl[CTRL_GO] && !complete) begin // RULE16
         d.phase  = PH_HOLD;                               // RULE17
         d.tick_n = '0;
         restart  = 1'b1;
      end

      // power off overrides the phase and the go bit
      if (!d.ctrl[CTRL_PWR]) begin                         // RULE24
         d.phase         = PH_OFF;
         d.ctrl[CTRL_GO] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register the state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q        <= '0;                                   // RULE22
         q.phase  <= PH_OFF;                               // RULE22
         q.ctrl   <= CTRL_RST;                             // RULE22
         q.fmt    <= FMT_RST;                              // RULE22
         q.res_hi <= RES_RST;
         q.res_lo <= RES_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign waitrequest              = (read || write) && !q.resp;
   assign readdata                 = q.rdata;
   assign conversion_done_irq_flag = q.done;

   always_comb begin
      front.powered      = powered;
      front.channel      = q.ctrl[CTRL_CH +: 3];           // RULE23
      front.connect      = (q.phase == PH_ACQ);            // RULE8
      front.vref_pos_ext = vpos;
      front.vref_neg_ext = vneg;
      front.trial        = q.sar;
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_left_justify: assert property (                       // RULE1
      complete && !q.fmt[FMT_RIGHT] |=> q.res_lo[5:0] == 6'h00 && q.done)
      else $error("left justified low bits not zero");

   a_right_justify: assert property (                      // RULE2
      complete && q.fmt[FMT_RIGHT] |=> q.res_hi[7:2] == 6'h00 && q.res_lo == $past(q.sar[7:0]))
      else $error("right justified result wrong");

   a_done_sets: assert property (                          // RULE5
      complete && d.ctrl[CTRL_PWR] |=> q.done && !q.ctrl[CTRL_GO] && q.phase == PH_HOLD)
      else $error("completion did not set done and clear go");

   a_holdoff_open: assert property (                       // RULE8
      $fell(q.phase == PH_CONV) |-> !front.connect [*2])
      else $error("capacitor connected during holdoff");

   a_conv_length: assert property (                        // RULE9
      complete |-> 32'(q.conv_cyc) + 1 >= CONV_TADS * 32'(tad_len))
      else $error("conversion shorter than twelve periods");

   a_analog_zero: assert property (                        // RULE15
      q.resp && read && address == REG_PORT |-> (q.rdata[4:0] & ~digital) == 5'h00)
      else $error("analog pin read back non-zero");

   a_abort_keeps: assert property (                        // RULE16
      converting && !d.ctrl[CTRL_GO] && !complete && d.ctrl[CTRL_PWR]
      |=> $stable(q.res_hi) && $stable(q.res_lo) && q.phase == PH_HOLD)
      else $error("abort changed result pair");

   a_off_idle: assert property (                           // RULE24
      !q.ctrl[CTRL_PWR] |-> q.phase == PH_OFF && !q.ctrl[CTRL_GO])
      else $error("converter active while powered off");

   a_ref_select: assert property (                         // RULE3
      q.fmt[3:0] == 4'h8 |-> front.vref_pos_ext && front.vref_neg_ext)
      else $error("reference select wrong for code 1000");

   a_first_seg: assert property (                          // RULE18
      $rose(q.phase == PH_FIRST) |-> ##[1:800] q.phase != PH_FIRST)
      else $error("first segment longer than one period");

   a_first_len: assert property (                          // RULE18
      q.phase == PH_FIRST |-> q.conv_cyc < tad_len)
      else $error("first segment outlasts one period");

   a_holdoff_len: assert property (                        // RULE8 RULE17
      q.phase == PH_HOLD && d.phase == PH_ACQ |-> 32'(q.hold_cyc) + 1 >= HOLD_TADS * 32'(tad_len))
      else $error("holdoff shorter than two periods");

   a_go_refused: assert property (                         // RULE24
      q.phase == PH_OFF || q.phase == PH_HOLD |=> !q.ctrl[CTRL_GO])
      else $error("go accepted outside acquisition");

   a_start_first: assert property (                        // RULE18
      q.phase == PH_ACQ && d.ctrl[CTRL_GO] |=> q.phase == PH_FIRST && q.conv_cyc == 16'h0000)
      else $error("start not taken into the first segment");

   a_done_keeps: assert property (                         // RULE5
      q.done && !(sw_we && address == REG_STATUS) |=> q.done)
      else $error("done flag lost without a clear");

   a_trial_msb: assert property (                          // RULE9
      q.phase == PH_FIRST && tick && d.ctrl[CTRL_GO] |=> q.phase == PH_CONV && q.sar == SAR_MSB)
      else $error("conversion did not start at the top bit");

   a_pin_table: assert property (                          // RULE4
      q.fmt[3:0] == 4'hE |-> digital == 5'h1E && !front.vref_pos_ext)
      else $error("code 1110 pin table wrong");

   a_off_parked: assert property (                         // RULE22
      !q.ctrl[CTRL_PWR] |-> !front.connect && !front.powered)
      else $error("front end active while powered off");

   a_abort_no_done: assert property (                      // RULE16
      converting && !d.ctrl[CTRL_GO] && !complete |=> $stable(q.done))
      else $error("abort changed the done flag");

endmodule

// file: adc_analog_model.sv
// analog far side: five input levels, a holding capacitor, a comparator.
// assumes the front controls of the converter block on the same clock.
`timescale 1ns/10ps
module adc_analog_model
   import adc_ctl_pkg::*;
(
   // clock
   input  wire logic        clk,
   // input levels, ten bits per channel
   input  wire logic [49:0] levels,
   // converter side
   input  wire front_type   front,
   output logic             comp_hi
);
   logic [9:0] held_q = 10'h000;                           // capacitor level

   ////////////////////////////////////////////////////////////////////////
   // capacitor follows the selected pin only while the switch is closed
   always_ff @(posedge clk) begin
      if (front.connect && front.channel < 3'h5) begin
         held_q <= levels[int'(front.channel) * 10 +: 10];
      end
   end

   // comparator: high while held level is at or above the trial code
   assign comp_hi = (held_q >= front.trial);
endmodule

// file: adc_conversion_control_tb.sv
// testbench for the converter control block: bus tasks, scenarios, verdict.
// assumes the analog model on the far side and a 200 MHz clock.
`timescale 1ns/10ps
module adc_conversion_control_tb;
   import adc_ctl_pkg::*;
   localparam int RC = 6;                                  // short rc period
   logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, comp_hi;
   logic [2:0]  address = 3'h0;                            // word index
   logic [31:0] writedata = 32'h0000_0000, readdata, rd;
   logic        waitrequest, done_flag;
   logic [4:0]  port_pins = 5'h1F;                         // all pins high
   logic [49:0] levels = {10'h111, 10'h2A5, 10'h0F0, 10'h3C3, 10'h055};
   front_type   front;
   int          num_errors = 0, check_count = 0, cyc = 0;

   ////////////////////////////////////////////////////////////////////////
   // clock, cycle count, reset
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   end

   // block and its analog far side
   adc_conv_ctl #(.RC_CYC(RC)) u_dut (.clk(clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .comp_hi(comp_hi), .port_pins(port_pins),
      .front(front), .conversion_done_irq_flag(done_flag));
   adc_analog_model u_ana (.clk(clk), .levels(levels), .front(front), .comp_hi(comp_hi));

   ////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task automatic summarize();
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one bus access; request held until waitrequest low at an edge
   task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      writedata <= {24'h00_0000, d};
      read <= ~wr;
      write <= wr;
      // answer and read data taken at the rising edge itself
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   // expected digital pins of a port code
   function automatic logic [4:0] dig(input logic [3:0] c);
      case (c)
         4'h4, 4'h5: dig = 5'h14;
         4'h6, 4'h7: dig = 5'h1F;
         4'hD: dig = 5'h10;
         4'hE: dig = 5'h1E;
         4'hF: dig = 5'h12;
         default: dig = 5'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset state, unmapped place, result bytes as plain registers
   task automatic t_reset();
      for (int a = 0; a < 7; a++) begin
         bus(1'b0, a[2:0], 8'h00);
         check(rd, 32'h0000_0000);
      end
      bus(1'b1, REG_RES_HI, 8'hA5);
      bus(1'b1, REG_RES_LO, 8'h3C);
      bus(1'b0, REG_RES_HI, 8'h00);
      check(rd, 32'h0000_00A5);
      bus(1'b0, REG_RES_LO, 8'h00);
      check(rd, 32'h0000_003C);
      bus(1'b1, REG_CTRL, 8'h04);
      bus(1'b0, REG_CTRL, 8'h00);
      check(rd, 32'h0000_0000);
   endtask

   // every port code: digital pins, reference pins, readback
   task automatic t_ports();
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, REG_FMT, {4'h7, c[3:0]});
         bus(1'b0, REG_PORT, 8'h00);
         check(rd, {27'h0, dig(c[3:0])});
         check({30'h0, front.vref_pos_ext, front.vref_neg_ext},
               {30'h0, c inside {1, 3, 5, 8, 10, 11, 12, 13, 15},
               c inside {8, 11, 12, 13, 15}});
      end
   endtask

   // one conversion, or an abort of one, with its timing and result
   task automatic t_conv(input logic [1:0] sel, input logic [2:0] ch, input logic fmt,
                         input int t, input logic ab, input logic [15:0] exp);
      int t0;
      bus(1'b1, REG_FMT, {fmt, 7'h00});
      bus(1'b1, REG_CTRL, {sel, ch, 3'h1});
      repeat (20) @(posedge clk);
      check({31'h0, front.connect}, 32'h0000_0001);
      check({28'h0, front.powered, front.channel}, {28'h0, 1'b1, ch});
      bus(1'b1, REG_CTRL, {sel, ch, 3'h5});
      t0 = cyc;
      if (ab) begin
         repeat (3 * t) @(posedge clk);
         bus(1'b1, REG_CTRL, {sel, ch, 3'h1});
         repeat (t) @(posedge clk);
         check({31'h0, front.connect}, 32'h0000_0000);
         repeat (t + 4) @(posedge clk);
         check({31'h0, front.connect}, 32'h0000_0001);
      end else begin
         rd = 32'h0000_0004;
         while (rd[2] === 1'b1 && cyc - t0 < 2000) bus(1'b0, REG_CTRL, 8'h00);
         check(32'(cyc - t0 >= 12 * t && cyc - t0 <= 12 * t + 8), 32'h1);
         check({31'h0, front.connect}, 32'h0000_0000);
         repeat (2 * t + 4) @(posedge clk);
         check({31'h0, front.connect}, 32'h0000_0001);
         check({31'h0, done_flag}, 32'h0000_0001);
      end
      bus(1'b0, REG_RES_HI, 8'h00);
      check(rd, {24'h0, exp[15:8]});
      bus(1'b0, REG_RES_LO, 8'h00);
      check(rd, {24'h0, exp[7:0]});
      bus(1'b1, REG_STATUS, 8'h00);
      bus(1'b0, REG_STATUS, 8'h00);
      check(rd, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      @(posedge rst_n);
      t_reset();
      t_ports();
      // rc period shortened for the run; rc used awake only to keep it short
      t_conv(2'h1, 3'h3, 1'b0, 8, 1'b0, 16'hA940);
      t_conv(2'h3, 3'h2, 1'b1, RC, 1'b0, 16'h00F0);
      t_conv(2'h2, 3'h0, 1'b0, 32, 1'b1, 16'h00F0);
      t_conv(2'h0, 3'h4, 1'b0, 2, 1'b1, 16'h00F0);
      summarize();
   end
   initial begin
      #400_000;
      num_errors++;
      summarize();
   end
endmodule
